// >>> rtl/xcvr_dir_pkg.sv
// shared constants and carrier types for the transceiver direction control
package xcvr_dir_pkg;

	// ***********************************
	// register map of the uart port window
	// ***********************************
	// port offset of the mode byte within the eight-byte uart window
	localparam logic [2:0] MODE_SEL_OFFSET = 3'h7;
	// mode byte after reset: four-wire
	localparam logic [7:0] MODE_SEL_RESET = 8'h00;

	// ***********************************
	// control bytes of the four modes
	// ***********************************
	localparam logic [7:0] CODE_FOUR_WIRE = 8'h00;
	localparam logic [7:0] CODE_TWO_ECHO = 8'h01;
	localparam logic [7:0] CODE_TWO_DTR = 8'h02;
	localparam logic [7:0] CODE_TWO_AUTO = 8'h03;

	// decoded transceiver mode
	typedef enum logic [1:0]
	{
		MODE_FOUR_WIRE = 2'h0,
		MODE_TWO_ECHO = 2'h1,
		MODE_TWO_DTR = 2'h2,
		MODE_TWO_AUTO = 2'h3
	} xcvr_mode_e;

	// ***********************************
	// carrier types
	// ***********************************
	// one host access on the uart port window
	typedef struct packed
	{
		logic [2:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} io_req_s;

	// enables toward the line transmitter and receiver, high = enabled
	typedef struct packed
	{
		logic tx_en;
		logic rx_en;
	} line_en_s;

endpackage

// >>> rtl/mode_byte_reg.sv
// holding register for the transceiver mode byte
`timescale 1ns/1ps

module mode_byte_reg
	import xcvr_dir_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// write side
	input wire logic wr_en,
	input wire logic [7:0] wdata,
	// stored byte
	output logic [7:0] byte_q
);

	// ***********************************
	// storage
	// ***********************************
	// reset loads zero, so the port wakes up in four-wire mode
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			byte_q <= MODE_SEL_RESET;
		end
		else if (wr_en)
		begin
			// the whole byte is kept so a read returns exactly what was written
			byte_q <= wdata;
		end
	end

endmodule

// >>> rtl/xcvr_dir_ctrl.sv
// transceiver direction control beside a uart, mode set through the scratch byte
// Contract
// - four-wire keeps transmitter and receiver always enabled
// - four-wire is the default mode
// - echo mode: transmitter follows dtr unasserted, receiver on
// - dtr mode: receiver on only while dtr asserted
// - auto mode: transmitter follows transmit-ready line
// - auto mode: receiver off while transmitter enabled
// - control bytes 0x00 to 0x03 pick modes
// - mode byte sits at offset 7, per port
// - new mode takes effect right after write
// - dtr and transmit-ready are active low
`timescale 1ns/1ps

module xcvr_dir_ctrl
	import xcvr_dir_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// host access on the uart port window
	input wire io_req_s io_req,
	output logic [7:0] io_rdata,
	output logic io_rd_valid,
	// modem and transmit state from the uart core, same clock
	input wire logic dtr_b,
	input wire logic uart_transmit_ready_line_b,
	// enables toward the rs-485 line drivers
	output line_en_s line_en,
	// current mode for status or leds
	output xcvr_mode_e mode
);

	// ***********************************
	// functions
	// ***********************************
	// map a written byte onto a mode; unknown bytes fall back to four-wire
	function automatic xcvr_mode_e decode_mode(input logic [7:0] code);
		xcvr_mode_e m;
		m = MODE_FOUR_WIRE;
		unique case (code)
			CODE_FOUR_WIRE: m = MODE_FOUR_WIRE;
			CODE_TWO_ECHO: m = MODE_TWO_ECHO;
			CODE_TWO_DTR: m = MODE_TWO_DTR;
			CODE_TWO_AUTO: m = MODE_TWO_AUTO;
			default: m = MODE_FOUR_WIRE;
		endcase
		return m;
	endfunction

	// derive the enables from mode and the two active-low uart signals
	function automatic line_en_s drive_lines(input xcvr_mode_e m, input logic dtr_in_b,
		input logic rdy_in_b);
		line_en_s e;
		logic dtr_on;
		logic rdy_on;
		dtr_on = ~dtr_in_b;
		rdy_on = ~rdy_in_b;
		e.tx_en = 1'b1;
		e.rx_en = 1'b1;
		unique case (m)
			MODE_FOUR_WIRE:
			begin
				e.tx_en = 1'b1;
				e.rx_en = 1'b1;
			end
			// transmitter only while dtr unasserted, receiver stays on
			MODE_TWO_ECHO:
			begin
				e.tx_en = ~dtr_on;
				e.rx_en = 1'b1;
			end
			// receiver is the complement of the transmitter
			MODE_TWO_DTR:
			begin
				e.tx_en = ~dtr_on;
				e.rx_en = dtr_on;
			end
			MODE_TWO_AUTO:
			begin
				e.tx_en = rdy_on;
				e.rx_en = ~rdy_on;
			end
		endcase
		return e;
	endfunction

	// ***********************************
	// address decode
	// ***********************************
	// access hits the mode byte
	logic sel_mode;
	// write strobe into the holding register
	logic mode_wr;
	// read strobe for the mode byte
	logic mode_rd;
	// stored mode byte
	logic [7:0] mode_byte;

	// only offset 7 of the window belongs to this block
	assign sel_mode = (io_req.addr == MODE_SEL_OFFSET);
	assign mode_wr = sel_mode && io_req.wr;
	assign mode_rd = sel_mode && io_req.rd;

	// ***********************************
	// mode byte storage
	// ***********************************
	// one instance per serial port keeps each port's mode independent
	mode_byte_reg u_mode_byte
	(
		.mclk(mclk),
		.rst_b(rst_b),
		.wr_en(mode_wr),
		.wdata(io_req.wdata),
		.byte_q(mode_byte)
	);

	// the decoded mode follows the stored byte with no extra step
	assign mode = decode_mode(mode_byte);

	// ***********************************
	// line enables
	// ***********************************
	// combinational from the registered mode and the uart signals, so the
	// transmitter opens in the same cycle that transmit-ready goes low;
	// the uart signals are registered in its core, so no glitches reach here
	assign line_en = drive_lines(mode, dtr_b, uart_transmit_ready_line_b);

	// ***********************************
	// read back
	// ***********************************
	// read data is registered and valid one cycle after the strobe
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			io_rdata <= MODE_SEL_RESET;
		end
		else if (mode_rd)
		begin
			io_rdata <= mode_byte;
		end
	end

	// valid pulse for the read data
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			io_rd_valid <= 1'b0;
		end
		else
		begin
			io_rd_valid <= mode_rd;
		end
	end

	// ***********************************
	// assertions
	// ***********************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	chk_four_wire_on: assert property (
		(mode == MODE_FOUR_WIRE) |-> (line_en.tx_en && line_en.rx_en))
		else $error("four-wire mode left an enable low");

	chk_reset_four_wire: assert property (
		@(posedge mclk) disable iff (1'b0)
		!rst_b |=> (mode == MODE_FOUR_WIRE && mode_byte == MODE_SEL_RESET))
		else $error("reset did not return to four-wire");

	chk_echo_mode_en: assert property (
		(mode == MODE_TWO_ECHO) |-> (line_en.tx_en == dtr_b && line_en.rx_en))
		else $error("echo mode enables wrong");

	chk_dtr_mode_en: assert property (
		(mode == MODE_TWO_DTR) |-> (line_en.tx_en == dtr_b && line_en.rx_en == !dtr_b))
		else $error("dtr mode enables wrong");

	chk_auto_tx_follow: assert property (
		(mode == MODE_TWO_AUTO && $fell(uart_transmit_ready_line_b)) |-> line_en.tx_en)
		else $error("auto mode transmitter not opened by transmit-ready");

	chk_auto_rx_off: assert property (
		(mode == MODE_TWO_AUTO) |-> (line_en.rx_en == uart_transmit_ready_line_b
			&& line_en.tx_en != line_en.rx_en))
		else $error("auto mode receiver on while sending");

	chk_write_takes_mode: assert property (
		mode_wr |=> (mode_byte == $past(io_req.wdata)))
		else $error("written mode not applied next cycle");

	chk_code_three_auto: assert property (
		(mode_wr && io_req.wdata == CODE_TWO_AUTO)
		|=> (mode == MODE_TWO_AUTO && line_en.rx_en == uart_transmit_ready_line_b))
		else $error("0x03 did not select auto mode");

	chk_other_offset: assert property (
		(io_req.wr && !sel_mode) |=> $stable(mode_byte))
		else $error("write to another offset changed the mode");

	chk_read_back: assert property (
		(mode_rd && !mode_wr) |=> (io_rd_valid && io_rdata == $past(mode_byte)))
		else $error("read back of mode byte wrong");

	cov_echo_tx: cover property ((mode == MODE_TWO_ECHO) ##1 $rose(line_en.tx_en));
	cov_dtr_turn: cover property ((mode == MODE_TWO_DTR) ##1 $fell(line_en.rx_en));
	cov_auto_byte: cover property ((mode == MODE_TWO_AUTO) ##1 line_en.tx_en ##1 line_en.rx_en);
	cov_back_to_four: cover property ((mode == MODE_TWO_AUTO) ##[1:20] (mode == MODE_FOUR_WIRE));

endmodule

// >>> testbench/line_xcvr_model.sv
// behavioural rs-485 line transmitter and receiver on a two-wire bus
`timescale 1ns/1ps

module line_xcvr_model
	import xcvr_dir_pkg::*;
(
	// enables and data from the card side
	input wire line_en_s line_en,
	input wire logic txd,
	// received bit toward the uart
	output logic rxd
);
	// bus idles high through the bias resistors when nobody drives it
	wire logic bus = line_en.tx_en ? txd : 1'b1;
	// last bit the receiver saw
	logic last = 1'b1;
	// a disabled receiver floats, so show the inverse of its last bit, never a stale copy
	always @(line_en.rx_en or bus)
		if (line_en.rx_en)
			last = bus;
	assign rxd = line_en.rx_en ? bus : ~last;
endmodule

// >>> testbench/test_xcvr_dir_ctrl.sv
// self-checking bench for the transceiver direction control
`timescale 1ns/1ps

module test_xcvr_dir_ctrl;
	import xcvr_dir_pkg::*;
	logic mclk, rst_b, dtr_b, rdy_b, rxd;
	io_req_s io_req;
	logic [7:0] io_rdata;
	logic io_rd_valid;
	line_en_s line_en;
	xcvr_mode_e mode;
	int bad_count = 0;
	int comparisons = 0;
	// rows: mode code, dtr_b, ready_b, expected tx_en, rx_en
	logic [5:0] rows [8] = '{6'h03, 6'h0F, 6'h11, 6'h1B, 6'h21, 6'h2A, 6'h32, 6'h35};

	xcvr_dir_ctrl dut_u (.mclk(mclk), .rst_b(rst_b), .io_req(io_req), .io_rdata(io_rdata),
		.io_rd_valid(io_rd_valid), .dtr_b(dtr_b), .uart_transmit_ready_line_b(rdy_b),
		.line_en(line_en), .mode(mode));
	// card side sends zeros so an enabled receiver hears its own low bits
	line_xcvr_model far_u (.line_en(line_en), .txd(1'b0), .rxd(rxd));

	// free-running 250 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// one comparison, counted
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one host access, strobes held for exactly one rising edge
	task automatic acc(input logic [2:0] a, input logic w, input logic r, input logic [7:0] d);
		@(negedge mclk);
		io_req = '{addr: a, wr: w, rd: r, wdata: d};
		@(negedge mclk);
		io_req = '0;
	endtask

	// read the mode byte and check the one-cycle answer
	task automatic rd(input logic [7:0] exp);
		acc(MODE_SEL_OFFSET, 1'b0, 1'b1, 8'h00);
		chk({7'h00, io_rd_valid}, 8'h01);
		chk(io_rdata, exp);
		@(negedge mclk);
		chk({7'h00, io_rd_valid}, 8'h00);
	endtask

	// counts, verdict and end of run
	task automatic conclude;
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// watchdog so a hang still reaches the verdict
	initial
	begin
		#100000;
		bad_count++;
		conclude();
	end

	// main sequence
	initial
	begin
		rst_b = 1'b0;
		io_req = '0;
		dtr_b = 1'b1;
		rdy_b = 1'b1;
		repeat (10) @(negedge mclk);
		rst_b = 1'b1;
		chk({6'h00, mode}, 8'h00);
		chk({6'h00, line_en}, 8'h03);
		rd(MODE_SEL_RESET);
		$display("test reset done");
		// each row: write the code, set the uart lines, check enables and echo
		for (int i = 0; i < 8; i++)
		begin
			acc(MODE_SEL_OFFSET, 1'b1, 1'b0, {6'h00, rows[i][5:4]});
			// host clears dtr (pin high) to send
			dtr_b = rows[i][3];
			rdy_b = rows[i][2];
			#1;
			chk({6'h00, mode}, {6'h00, rows[i][5:4]});
			chk({6'h00, line_en}, {6'h00, rows[i][1:0]});
			if (rows[i][0])
				chk({7'h00, rxd}, {7'h00, ~rows[i][1]});
		end
		$display("test mode table done");
		// writes and reads at other offsets never touch the mode byte
		acc(3'h6, 1'b1, 1'b0, CODE_TWO_DTR);
		chk({6'h00, mode}, 8'h03);
		acc(3'h5, 1'b0, 1'b1, 8'h00);
		chk({7'h00, io_rd_valid}, 8'h00);
		// write and read together: old byte comes back, unknown code is four-wire
		acc(3'h7, 1'b1, 1'b1, 8'hFF);
		chk(io_rdata, CODE_TWO_AUTO);
		chk({6'h00, line_en}, 8'h03);
		rd(8'hFF);
		$display("test offsets done");
		// auto mode: one byte leaves while transmit-ready is low
		// uart fifos taken as enabled here
		acc(MODE_SEL_OFFSET, 1'b1, 1'b0, CODE_TWO_AUTO);
		rdy_b = 1'b1;
		@(negedge mclk);
		rdy_b = 1'b0;
		#1;
		chk({6'h00, line_en}, 8'h02);
		repeat (3) @(negedge mclk);
		chk({6'h00, line_en}, 8'h02);
		rdy_b = 1'b1;
		#1;
		chk({6'h00, line_en}, 8'h01);
		chk({7'h00, rxd}, 8'h01);
		$display("test auto byte done");
		// reset in mid-run returns to four-wire
		acc(MODE_SEL_OFFSET, 1'b1, 1'b0, CODE_TWO_DTR);
		chk({6'h00, mode}, 8'h02);
		@(negedge mclk);
		rst_b = 1'b0;
		@(negedge mclk);
		rst_b = 1'b1;
		chk({6'h00, mode}, 8'h00);
		chk({6'h00, line_en}, 8'h03);
		chk({7'h00, io_rd_valid}, 8'h00);
		rd(8'h00);
		$display("test second reset done");
		conclude();
	end
endmodule
